/* File: common/link_mode_defs.svh */
// Register map, field positions, reset values and limits of the link mode block.
`ifndef LINK_MODE_DEFS_SVH
`define LINK_MODE_DEFS_SVH

// ==========================================================
// Register offsets
`define REG_EDID_BRIDGE_CONTROL   8'h4F
`define REG_BRIDGE_CFG   8'h54
`define REG_PAIRING      8'h5B

// ==========================================================
// Field positions
`define BIT_ID_OFF       0
`define BIT_AUDIO_AUX    1
`define BIT_FAR_COPY     5
`define BIT_EXT_CTRL     7
`define BIT_AUTO_OFF     0
`define FORCE_LSB        1
`define FORCE_MSB        2
`define BIT_PLL_RST      5
`define BIT_CABLE        7

// ==========================================================
// Reset values
`define RST_EDID_BRIDGE_CONTROL   8'h00
`define RST_BRIDGE_CFG   8'h00
`define RST_PAIRING      8'h20
`define RD_UNMAPPED      8'h00

// ==========================================================
// Forced link modes
`define FORCE_SINGLE     2'h0
`define FORCE_DUAL       2'h1
`define FORCE_REPL       2'h2
`define FORCE_SEC        2'h3

// ==========================================================
// Pixel clock limits in MHz
`define SINGLE_MAX_MHZ   8'h60
`define OLD_MAX_MHZ      8'h55
`define DUAL_MAX_MHZ     8'hAA
`define REPL_MAX_MHZ     8'h55
`define DUAL_MIN_MHZ     8'h61

// ==========================================================
// Target address decode and power-up capture
`define ADDR_BASE        7'h0C
`define ADDR_STEP        7'h02
`define SETTLE_CYC       2'h3

`endif

/* File: common/link_mode_pkg.sv */
// Types shared by the link mode and strap configuration block.
package link_mode_pkg;

	typedef enum logic [2:0] {
		LM_IDLE,
		LM_SINGLE,
		LM_SECONDARY_ONLY,
		LM_DUAL,
		LM_REPLICATE
	} link_mode_t;

	typedef struct packed {
		logic ext_ctrl;
		logic cable;
		logic far_copy;
	} strap_bits_t;

	typedef struct packed {
		logic primary;
		logic secondary;
		logic dual_cap;
		logic new_gen;
	} rx_detect_t;

	typedef enum logic [3:0] {
		TS_IDLE,
		TS_ADDR,
		TS_ADDR_ACK,
		TS_PTR,
		TS_PTR_ACK,
		TS_WDATA,
		TS_WDATA_ACK,
		TS_RDATA,
		TS_RDATA_ACK
	} tgt_state_t;

endpackage : link_mode_pkg

/* File: rtl/link_mode_select.sv */
// Downstream link mode selection from receiver detection and pixel clock.
`timescale 1ns/1ps
`include "link_mode_defs.svh"

module link_mode_select (
	input  wire logic                     mclk_i,
	input  wire logic                     rstn_i,
	input  wire logic                     auto_off_i,
	input  wire logic [1:0]               force_mode_i,
	input  wire link_mode_pkg::rx_detect_t rx_i,
	input  wire logic [7:0]               pclk_mhz_i,
	output link_mode_pkg::link_mode_t     mode_o,
	output logic                          rate_over_o
);
	import link_mode_pkg::*;

	link_mode_t mode_d;

	// ==========================================================
	// Rate ceiling of each mode
	function automatic logic [7:0] mode_limit(input link_mode_t m, input logic new_gen);
		case (m)
			LM_SINGLE, LM_SECONDARY_ONLY: mode_limit = new_gen ? `SINGLE_MAX_MHZ
			                                                   : `OLD_MAX_MHZ;
			LM_DUAL:      mode_limit = `DUAL_MAX_MHZ;
			LM_REPLICATE: mode_limit = `REPL_MAX_MHZ;
			default:      mode_limit = 8'hFF;
		endcase
	endfunction : mode_limit

	// ==========================================================
	// Mode decision
	always_comb begin
		mode_d = LM_IDLE;
		if (!auto_off_i) begin
			// Detection is combined with the measured clock.
			if (rx_i.primary && rx_i.secondary && !rx_i.dual_cap) begin
				mode_d = LM_REPLICATE;
			end else if (rx_i.primary && rx_i.dual_cap && pclk_mhz_i >= `DUAL_MIN_MHZ) begin
				mode_d = LM_DUAL;
			end else if (rx_i.primary) begin
				mode_d = LM_SINGLE;
			end else if (rx_i.secondary) begin
				mode_d = LM_SECONDARY_ONLY;
			end
		end else begin
			// Forced modes ignore what is detected downstream.
			case (force_mode_i)
				`FORCE_SINGLE: mode_d = LM_SINGLE;
				`FORCE_DUAL:   mode_d = LM_DUAL;
				`FORCE_REPL:   mode_d = LM_REPLICATE;
				`FORCE_SEC:    mode_d = LM_SECONDARY_ONLY;
				default:       mode_d = LM_SINGLE;
			endcase
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!rstn_i) begin
			mode_o <= LM_IDLE;
		end else begin
			mode_o <= mode_d;
		end
	end

	// Flags a pixel clock above what the chosen mode can carry.
	always_ff @(posedge mclk_i) begin
		if (!rstn_i) begin
			rate_over_o <= 1'b0;
		end else begin
			rate_over_o <= (mode_d != LM_IDLE) && (pclk_mhz_i > mode_limit(mode_d, rx_i.new_gen));
		end
	end

endmodule : link_mode_select

/* File: rtl/link_mode_strap_config.sv */
// Strap capture, control bus registers and link mode control of the bridge.
// ==========================================================
// Summary of operation
// - Eight-level strap gives three bits, level minus one
// - Display-ID source strap lands in 0x4F bit 0
// - Audio strap lands in 0x54 bit 1
// - External-control strap lands in 0x54 bit 7
// - Cable-type strap lands in 0x5B bit 7
// - Far-copy strap lands in 0x54 bit 5
// - Captured bits stay readable and writable
// - Single mode: one link, 96 MHz newer
// - Older receiver single mode up to 85 MHz
// - Forced single disables secondary PHY, back channel
// - Dual mode sends alternate pixels per link
// - Dual up to 170 MHz, ports half rate
// - Dual chosen automatically or forced by register
// - Replicate: same video to both, 85 MHz
// - Two single receivers select replicate automatically
// - Detection class plus pixel clock chooses mode
// - Only secondary present: send on secondary only
// - Auto-detection can be disabled by register
// - Bus target uses one of eight addresses
// - Levels 1 and 2 give 0x0C, 0x0E
// - Data line driven low or released only
// - Strap values captured once at power-up
// - External-control bit hands input to bus pins
// - Cable-type bit selects twisted pair or cable_kind_strap
// - Levels 3 to 8 give 0x10 to 0x1A
`timescale 1ns/1ps
`include "link_mode_defs.svh"

module link_mode_strap_config (
	input  wire logic                      mclk_i,
	input  wire logic                      rstn_i,
	input  wire logic                      scl_i,
	input  wire logic                      sda_i,
	output logic                           sda_o,
	output logic                           sda_oe_o,
	input  wire logic [2:0]                second_config_strap_i,
	input  wire logic [1:0]                first_config_strap_i,
	input  wire logic [2:0]                address_strap_pin_i,
	input  wire link_mode_pkg::rx_detect_t rx_i,
	input  wire logic [7:0]                pclk_mhz_i,
	output link_mode_pkg::link_mode_t      link_mode_o,
	output logic                           rate_over_o,
	output logic                           primary_tx_en_o,
	output logic                           secondary_tx_en_o,
	output logic                           secondary_bc_en_o,
	output logic                           pixel_split_o,
	output logic                           tx_half_rate_o,
	output logic                           external_input_ctrl_o,
	output logic                           cable_cable_kind_strap_o,
	output logic                           display_id_off_o,
	output logic                           far_display_id_copy_o,
	output logic                           audio_aux_o,
	output logic                           pll_reset_on_freq_change_o
);
	import link_mode_pkg::*;

	// ==========================================================
	// Pin synchronisers
	logic [1:0] scl_q, sda_q;
	logic       scl_prev_q, sda_prev_q;
	logic [2:0] sel1_m_q, sel1_q, idx_m_q, idx_q;
	logic [1:0] sel0_m_q, sel0_q;

	always_ff @(posedge mclk_i) begin
		if (!rstn_i) begin
			scl_q      <= 2'h3;
			sda_q      <= 2'h3;
			scl_prev_q <= 1'b1;
			sda_prev_q <= 1'b1;
		end else begin
			scl_q      <= {scl_q[0], scl_i};
			sda_q      <= {sda_q[0], sda_i};
			scl_prev_q <= scl_q[1];
			sda_prev_q <= sda_q[1];
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!rstn_i) begin
			sel1_m_q <= 3'h0;
			sel1_q   <= 3'h0;
			sel0_m_q <= 2'h0;
			sel0_q   <= 2'h0;
			idx_m_q  <= 3'h0;
			idx_q    <= 3'h0;
		end else begin
			sel1_m_q <= second_config_strap_i;
			sel1_q   <= sel1_m_q;
			sel0_m_q <= first_config_strap_i;
			sel0_q   <= sel0_m_q;
			idx_m_q  <= address_strap_pin_i;
			idx_q    <= idx_m_q;
		end
	end

	wire logic scl_s    = scl_q[1];
	wire logic sda_s    = sda_q[1];
	wire logic scl_rise = scl_s & ~scl_prev_q;
	wire logic scl_fall = ~scl_s & scl_prev_q;
	wire logic start_ev = scl_s & scl_prev_q & ~sda_s & sda_prev_q;
	wire logic stop_ev  = scl_s & scl_prev_q & sda_s & ~sda_prev_q;

	// ==========================================================
	// Power-up strap capture
	logic [1:0]  settle_q;
	logic        cap_done_q;
	logic        cap_pulse;
	logic [6:0]  dev_addr_q;
	strap_bits_t strap;

	// The encoded strap code is already level minus one.
	assign strap     = strap_bits_t'(sel1_q);
	assign cap_pulse = (settle_q == `SETTLE_CYC) && !cap_done_q;

	// Waits for the synchronisers to fill, then captures exactly once.
	always_ff @(posedge mclk_i) begin
		if (!rstn_i) begin
			settle_q   <= 2'h0;
			cap_done_q <= 1'b0;
		end else begin
			if (settle_q != `SETTLE_CYC) begin
				settle_q <= settle_q + 2'h1;
			end
			if (cap_pulse) begin
				cap_done_q <= 1'b1;
			end
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!rstn_i) begin
			dev_addr_q <= `ADDR_BASE;
		end else if (cap_pulse) begin
			dev_addr_q <= `ADDR_BASE + 7'(idx_q) * `ADDR_STEP;
		end
	end

	// ==========================================================
	// Control bus target
	tgt_state_t st_q;
	logic [7:0] sh_q, tx_q, ptr_q;
	logic [2:0] cnt_q;
	logic       done_q, rw_q, wr_q;
	logic [7:0] rd_data;
	logic [7:0] ctl_q, cfg_q, pair_q;

	always_comb begin
		case (ptr_q)
			`REG_EDID_BRIDGE_CONTROL: rd_data = ctl_q;
			`REG_BRIDGE_CFG: rd_data = cfg_q;
			`REG_PAIRING:    rd_data = pair_q;
			default:         rd_data = `RD_UNMAPPED;
		endcase
	end

	// Acknowledge slots carry no data bit, so they must not advance the count.
	wire logic ack_slot = st_q inside {TS_ADDR_ACK, TS_PTR_ACK, TS_WDATA_ACK, TS_RDATA_ACK};
	always_ff @(posedge mclk_i) begin
		if (!rstn_i || start_ev) begin
			cnt_q  <= 3'h0;
			done_q <= 1'b0;
			sh_q   <= 8'h00;
		end else if (scl_rise && !ack_slot) begin
			sh_q   <= {sh_q[6:0], sda_s};
			cnt_q  <= cnt_q + 3'h1;
			done_q <= (cnt_q == 3'h7);
		end else if (scl_fall && done_q) begin
			done_q <= 1'b0;
		end
	end

	// The data line is only ever pulled low; a one is a release.
	always_ff @(posedge mclk_i) begin
		if (!rstn_i) begin
			sda_o <= 1'b0;
		end else begin
			sda_o <= 1'b0;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!rstn_i || start_ev || stop_ev) begin
			st_q     <= start_ev ? TS_ADDR : TS_IDLE;
			sda_oe_o <= 1'b0;
			wr_q     <= 1'b0;
			if (!rstn_i) begin
				rw_q  <= 1'b0;
				tx_q  <= 8'h00;
				ptr_q <= 8'h00;
			end
		end else begin
			wr_q <= 1'b0;
			if (wr_q) begin
				ptr_q <= ptr_q + 8'h01;
			end
			if (scl_rise && st_q == TS_RDATA_ACK && sda_s) begin
				st_q <= TS_IDLE;
			end
			if (scl_fall) begin
				case (st_q)
					TS_ADDR, TS_PTR, TS_WDATA: begin
						if (done_q) begin
							if (st_q == TS_ADDR && sh_q[7:1] != dev_addr_q) begin
								st_q <= TS_IDLE;
							end else begin
								sda_oe_o <= 1'b1;
								st_q     <= tgt_state_t'(st_q + 4'h1);
								if (st_q == TS_ADDR) rw_q <= sh_q[0];
								if (st_q == TS_PTR) ptr_q <= sh_q;
								wr_q <= (st_q == TS_WDATA);
							end
						end
					end
					TS_ADDR_ACK, TS_RDATA_ACK: begin
						if (st_q == TS_ADDR_ACK && !rw_q) begin
							sda_oe_o <= 1'b0;
							st_q     <= TS_PTR;
						end else begin
							tx_q     <= rd_data;
							sda_oe_o <= ~rd_data[7];
							st_q     <= TS_RDATA;
						end
					end
					TS_PTR_ACK, TS_WDATA_ACK: begin
						sda_oe_o <= 1'b0;
						st_q     <= TS_WDATA;
					end
					TS_RDATA: begin
						if (done_q) begin
							sda_oe_o <= 1'b0;
							ptr_q    <= ptr_q + 8'h01;
							st_q     <= TS_RDATA_ACK;
						end else begin
							tx_q     <= {tx_q[6:0], 1'b0};
							sda_oe_o <= ~tx_q[6];
						end
					end
					default: sda_oe_o <= 1'b0;
				endcase
			end
		end
	end

	// Written byte is taken from the shifter one cycle after the acknowledge
	// starts; the shifter cannot move until the next rising clock edge.
	// ==========================================================
	// Register file
	always_ff @(posedge mclk_i) begin
		if (!rstn_i) begin
			ctl_q <= `RST_EDID_BRIDGE_CONTROL;
		end else if (cap_pulse) begin
			ctl_q[`BIT_ID_OFF] <= sel0_q[1];
		end else if (wr_q && ptr_q == `REG_EDID_BRIDGE_CONTROL) begin
			ctl_q <= sh_q;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!rstn_i) begin
			cfg_q <= `RST_BRIDGE_CFG;
		end else if (cap_pulse) begin
			cfg_q[`BIT_AUDIO_AUX] <= sel0_q[0];
			cfg_q[`BIT_EXT_CTRL]  <= strap.ext_ctrl;
			cfg_q[`BIT_FAR_COPY]  <= strap.far_copy;
		end else if (wr_q && ptr_q == `REG_BRIDGE_CFG) begin
			cfg_q <= sh_q;
		end
	end

	// Bit 5 comes up set; software clears it when setup is finished.
	always_ff @(posedge mclk_i) begin
		if (!rstn_i) begin
			pair_q <= `RST_PAIRING;
		end else if (cap_pulse) begin
			pair_q[`BIT_CABLE] <= strap.cable;
		end else if (wr_q && ptr_q == `REG_PAIRING) begin
			pair_q <= sh_q;
		end
	end

	// ==========================================================
	// Link mode and data path enables
	link_mode_select u_select (
		.mclk_i       (mclk_i),
		.rstn_i       (rstn_i),
		.auto_off_i   (pair_q[`BIT_AUTO_OFF]),
		.force_mode_i (pair_q[`FORCE_MSB:`FORCE_LSB]),
		.rx_i         (rx_i),
		.pclk_mhz_i   (pclk_mhz_i),
		.mode_o       (link_mode_o),
		.rate_over_o  (rate_over_o)
	);

	always_ff @(posedge mclk_i) begin
		if (!rstn_i) begin
			primary_tx_en_o   <= 1'b0;
			secondary_tx_en_o <= 1'b0;
			secondary_bc_en_o <= 1'b0;
			pixel_split_o     <= 1'b0;
			tx_half_rate_o    <= 1'b0;
		end else begin
			primary_tx_en_o   <= link_mode_o inside {LM_SINGLE, LM_DUAL, LM_REPLICATE};
			secondary_tx_en_o <= link_mode_o inside {LM_SECONDARY_ONLY, LM_DUAL,
			                                         LM_REPLICATE};
			// In automatic single mode the secondary stays up only for its back channel; forced single turns it off.
			secondary_bc_en_o <= (link_mode_o != LM_IDLE)
			                  && !(pair_q[`BIT_AUTO_OFF]
			                  && pair_q[`FORCE_MSB:`FORCE_LSB] == `FORCE_SINGLE);
			pixel_split_o     <= (link_mode_o == LM_DUAL);
			tx_half_rate_o    <= (link_mode_o == LM_DUAL);
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!rstn_i) begin
			external_input_ctrl_o      <= 1'b0;
			cable_cable_kind_strap_o               <= 1'b0;
			display_id_off_o           <= 1'b0;
			far_display_id_copy_o      <= 1'b0;
			audio_aux_o                <= 1'b0;
			pll_reset_on_freq_change_o <= 1'b1;
		end else begin
			external_input_ctrl_o      <= cfg_q[`BIT_EXT_CTRL];
			cable_cable_kind_strap_o               <= pair_q[`BIT_CABLE];
			display_id_off_o           <= ctl_q[`BIT_ID_OFF];
			far_display_id_copy_o      <= cfg_q[`BIT_FAR_COPY];
			audio_aux_o                <= cfg_q[`BIT_AUDIO_AUX];
			pll_reset_on_freq_change_o <= pair_q[`BIT_PLL_RST];
		end
	end

endmodule : link_mode_strap_config

/* File: verification/link_mode_strap_config_props.sv */
// Port-level concurrent checks for the link mode and strap block.
`timescale 1ns/1ps
`include "link_mode_defs.svh"

module link_mode_strap_config_props
	import link_mode_pkg::*;
(
	input wire logic                      mclk_i,
	input wire logic                      rstn_i,
	input wire logic                      scl_i,
	input wire logic                      sda_i,
	input wire logic                      sda_o,
	input wire logic                      sda_oe_o,
	input wire logic [7:0]                pclk_mhz_i,
	input wire link_mode_pkg::link_mode_t link_mode_o,
	input wire logic                      rate_over_o,
	input wire logic                      primary_tx_en_o,
	input wire logic                      secondary_tx_en_o,
	input wire logic                      secondary_bc_en_o,
	input wire logic                      pixel_split_o,
	input wire logic                      tx_half_rate_o,
	input wire logic                      external_input_ctrl_o,
	input wire logic                      cable_cable_kind_strap_o,
	input wire logic                      far_display_id_copy_o
);
	// ==========================================================
	// Helpers
	// Strap capture lands a few cycles after reset, so idle checks wait it out.
	logic [3:0] up_q;
	always_ff @(posedge mclk_i) begin
		if (!rstn_i)
			up_q <= 4'h0;
		else if (up_q != 4'hF)
			up_q <= up_q + 4'h1;
	end
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!rstn_i);
	sequence bus_idle;
		up_q == 4'hF && scl_i && sda_i;
	endsequence
	sequence dual_steady;
		link_mode_o == LM_DUAL && $stable(pclk_mhz_i);
	endsequence
	sequence repl_steady;
		link_mode_o == LM_REPLICATE && $stable(pclk_mhz_i);
	endsequence
	// ==========================================================
	// Assertions
	a_dual_split_on: assert property (link_mode_o == LM_DUAL |=>
		pixel_split_o && tx_half_rate_o) else $error("dual mode without split");
	a_repl_both_links: assert property (link_mode_o == LM_REPLICATE |=>
		primary_tx_en_o && secondary_tx_en_o && !pixel_split_o) else $error("replicate links");
	a_sec_only_link: assert property (link_mode_o == LM_SECONDARY_ONLY |=>
		!primary_tx_en_o && secondary_tx_en_o) else $error("secondary-only links");
	a_single_one_link: assert property (link_mode_o == LM_SINGLE |=>
		primary_tx_en_o && !pixel_split_o) else $error("single mode links");
	a_idle_links_off: assert property (link_mode_o == LM_IDLE |=>
		!primary_tx_en_o && !secondary_bc_en_o) else $error("idle mode links on");
	a_sda_low_only: assert property (sda_oe_o |-> !sda_o) else $error("data pin driven high");
	a_ack_scl_low: assert property ($changed(sda_oe_o) |-> !scl_i) else $error("data moved");
	a_dual_rate_top: assert property (dual_steady [*3] |->
		rate_over_o == (pclk_mhz_i > `DUAL_MAX_MHZ)) else $error("dual rate flag");
	a_repl_rate_top: assert property (repl_steady [*3] |->
		rate_over_o == (pclk_mhz_i > `REPL_MAX_MHZ)) else $error("replicate rate flag");
	a_strap_held: assert property (bus_idle [*8] |-> $stable(external_input_ctrl_o) &&
		$stable(cable_cable_kind_strap_o) && $stable(far_display_id_copy_o)) else $error("strap bit moved");
endmodule : link_mode_strap_config_props

bind link_mode_strap_config link_mode_strap_config_props u_props (
	.mclk_i, .rstn_i, .scl_i, .sda_i, .sda_o, .sda_oe_o, .pclk_mhz_i, .link_mode_o,
	.rate_over_o, .primary_tx_en_o, .secondary_tx_en_o, .secondary_bc_en_o, .pixel_split_o,
	.tx_half_rate_o, .external_input_ctrl_o, .cable_cable_kind_strap_o, .far_display_id_copy_o
);

/* File: verification/rx_partner.sv */
// Behavioural downstream receivers as seen by the link detection.
`timescale 1ns/1ps

module rx_partner
	import link_mode_pkg::*;
(
	input  wire logic                 mclk_i,
	input  wire logic [2:0]           kind_i,
	output link_mode_pkg::rx_detect_t rx_o
);
	// ==========================================================
	// Detection answer
	// A cable change is seen one clock later, as a real probe would lag.
	always_ff @(posedge mclk_i) begin
		case (kind_i)
			3'h1: rx_o <= 4'h9;
			3'h2: rx_o <= 4'h8;
			3'h3: rx_o <= 4'hF;
			3'h4: rx_o <= 4'hD;
			3'h5: rx_o <= 4'h5;
			default: rx_o <= 4'h0;
		endcase
	end
endmodule : rx_partner

/* File: verification/link_mode_strap_config_test.sv */
// Self-checking bench for the link mode and strap block.
`timescale 1ns/1ps

module link_mode_strap_config_test;
	import link_mode_pkg::*;
	// ==========================================================
	// Signals and instances
	logic       mclk_i, rstn_i, scl_m, sda_m, sda_o, sda_oe, ack;
	logic       p_en, s_en, bc, split, half, over, ext, cable_kind_strap, idoff, far, aud, pll;
	logic [2:0] sel2, adr, kind;
	logic [1:0] sel1;
	logic [7:0] pclk;
	logic [6:0] dev;
	wire        sda_w;
	link_mode_t mode;
	rx_detect_t rx;
	int         err_count, num_checks;
	assign sda_w = sda_m & ~sda_oe;
	rx_partner u_rx (.mclk_i(mclk_i), .kind_i(kind), .rx_o(rx));
	link_mode_strap_config dut (.mclk_i(mclk_i), .rstn_i(rstn_i), .scl_i(scl_m),
		.sda_i(sda_w), .sda_o(sda_o), .sda_oe_o(sda_oe), .second_config_strap_i(sel2),
		.first_config_strap_i(sel1), .address_strap_pin_i(adr), .rx_i(rx),
		.pclk_mhz_i(pclk), .link_mode_o(mode), .rate_over_o(over), .primary_tx_en_o(p_en),
		.secondary_tx_en_o(s_en), .secondary_bc_en_o(bc), .pixel_split_o(split),
		.tx_half_rate_o(half), .external_input_ctrl_o(ext), .cable_cable_kind_strap_o(cable_kind_strap),
		.display_id_off_o(idoff), .far_display_id_copy_o(far), .audio_aux_o(aud),
		.pll_reset_on_freq_change_o(pll));
	initial begin
		mclk_i = 1'b0;
		forever #20 mclk_i = ~mclk_i;
	end
	// ==========================================================
	// Shared tasks
	task automatic tick(input int n);
		repeat (n) @(posedge mclk_i);
	endtask : tick
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic chk_mode(input link_mode_t got, input link_mode_t exp);
		chk({5'h0, got}, {5'h0, exp});
	endtask : chk_mode
	// Bus pins move two cycles after a clock edge so the synchronisers never race.
	task automatic pbit(input logic b, output logic r);
		tick(2);
		sda_m <= b;
		tick(10);
		scl_m <= 1'b1;
		tick(10);
		r = sda_w;
		scl_m <= 1'b0;
	endtask : pbit
	task automatic start_c;
		tick(2);
		sda_m <= 1'b1;
		tick(2);
		scl_m <= 1'b1;
		tick(10);
		sda_m <= 1'b0;
		tick(10);
		scl_m <= 1'b0;
	endtask : start_c
	task automatic stop_c;
		tick(2);
		sda_m <= 1'b0;
		tick(2);
		scl_m <= 1'b1;
		tick(10);
		sda_m <= 1'b1;
		tick(10);
	endtask : stop_c
	task automatic wbyte(input logic [7:0] v, output logic a);
		logic r;
		for (int i = 7; i >= 0; i--) pbit(v[i], r);
		pbit(1'b1, r);
		a = ~r;
	endtask : wbyte
	task automatic rbyte(output logic [7:0] v);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			pbit(1'b1, r);
			v[i] = r;
		end
		pbit(1'b1, r);
	endtask : rbyte
	task automatic reg_wr(input logic [7:0] p, input logic [7:0] d);
		logic k0, k1, k2;
		start_c();
		wbyte({dev, 1'b0}, k0);
		wbyte(p, k1);
		wbyte(d, k2);
		stop_c();
		chk({5'h0, k0, k1, k2}, 8'h07);
	endtask : reg_wr
	task automatic reg_rd(input logic [7:0] p, output logic [7:0] d);
		logic k0, k1, k2;
		start_c();
		wbyte({dev, 1'b0}, k0);
		wbyte(p, k1);
		start_c();
		wbyte({dev, 1'b1}, k2);
		rbyte(d);
		stop_c();
		chk({5'h0, k0, k1, k2}, 8'h07);
	endtask : reg_rd
	task automatic mode_case(input logic [2:0] k, input logic [7:0] f, input link_mode_t m,
		input logic o);
		kind <= k;
		pclk <= f;
		tick(6);
		chk_mode(mode, m);
		chk({7'h0, over}, {7'h0, o});
	endtask : mode_case
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : give_verdict
	// ==========================================================
	// Scenarios
	task automatic t_straps;
		logic [7:0] v;
		for (int k = 0; k < 8; k++) begin
			sel2 <= k[2:0];
			sel1 <= ~k[1:0];
			adr <= k[2:0];
			tick(1);
			rstn_i <= 1'b0;
			tick(16);
			rstn_i <= 1'b1;
			tick(12);
			dev = 7'h0C + 7'(2 * k);
			chk({5'h0, ext, cable_kind_strap, far}, 8'(k));
			chk({5'h0, pll, idoff, aud}, {5'h0, 1'b1, ~k[1:0]});
			reg_rd(8'h54, v);
			chk(v, {k[2], 1'b0, k[0], 3'h0, ~k[0], 1'b0});
			reg_rd(8'h5B, v);
			chk(v, {k[1], 7'h20});
			sel2 <= ~k[2:0];
			tick(20);
			chk({5'h0, ext, cable_kind_strap, far}, 8'(k));
			start_c();
			wbyte({dev + 7'h02, 1'b0}, ack);
			stop_c();
			chk({7'h0, ack}, 8'h00);
		end
		$display("strap capture test done");
	endtask : t_straps
	task automatic t_override;
		logic [7:0] v;
		reg_wr(8'h54, 8'h00);
		reg_wr(8'h4F, 8'h01);
		reg_wr(8'h5B, 8'h80);
		tick(4);
		chk({2'h0, ext, far, aud, idoff, cable_kind_strap, pll}, 8'h06);
		reg_wr(8'h54, 8'hA2);
		reg_rd(8'h54, v);
		chk(v, 8'hA2);
		chk({5'h0, ext, far, aud}, 8'h07);
		reg_rd(8'h30, v);
		chk(v, 8'h00);
		chk({7'h0, sda_o}, 8'h00);
		$display("register override test done");
	endtask : t_override
	task automatic t_auto;
		mode_case(3'h1, 8'h60, LM_SINGLE, 1'b0);
		mode_case(3'h1, 8'h61, LM_SINGLE, 1'b1);
		mode_case(3'h2, 8'h55, LM_SINGLE, 1'b0);
		mode_case(3'h2, 8'h56, LM_SINGLE, 1'b1);
		mode_case(3'h3, 8'h60, LM_SINGLE, 1'b0);
		mode_case(3'h3, 8'h61, LM_DUAL, 1'b0);
		mode_case(3'h3, 8'hAA, LM_DUAL, 1'b0);
		mode_case(3'h3, 8'hAB, LM_DUAL, 1'b1);
		chk({6'h0, split, half}, 8'h03);
		mode_case(3'h4, 8'h55, LM_REPLICATE, 1'b0);
		mode_case(3'h4, 8'h56, LM_REPLICATE, 1'b1);
		mode_case(3'h5, 8'h50, LM_SECONDARY_ONLY, 1'b0);
		mode_case(3'h0, 8'h50, LM_IDLE, 1'b0);
		$display("auto detection test done");
	endtask : t_auto
	task automatic t_forced;
		link_mode_t fm[4];
		fm = '{LM_SINGLE, LM_DUAL, LM_REPLICATE, LM_SECONDARY_ONLY};
		kind <= 3'h4;
		for (int m = 0; m < 4; m++) begin
			reg_wr({5'h0, 2'(m), 1'b1}, 8'h00);
			reg_wr(8'h5B, {5'h0, 2'(m), 1'b1});
			tick(4);
			chk_mode(mode, fm[m]);
			chk({5'h0, p_en, s_en, bc}, (m == 0) ? 8'h04 : (m == 3) ? 8'h03 : 8'h07);
		end
		kind <= 3'h0;
		tick(6);
		chk_mode(mode, LM_SECONDARY_ONLY);
		reg_wr(8'h5B, 8'h00);
		tick(4);
		chk_mode(mode, LM_IDLE);
		$display("forced mode test done");
	endtask : t_forced
	// ==========================================================
	// Sequence and watchdog
	initial begin
		tick(90000);
		err_count++;
		give_verdict();
	end
	initial begin
		rstn_i = 1'b0;
		scl_m = 1'b1;
		sda_m = 1'b1;
		sel2 = 3'h0;
		sel1 = 2'h0;
		adr = 3'h0;
		kind = 3'h0;
		pclk = 8'h00;
		err_count = 0;
		num_checks = 0;
		t_straps();
		t_override();
		t_auto();
		t_forced();
		give_verdict();
	end
endmodule : link_mode_strap_config_test
